/* rtl/mcss_consts.svh */
// How it works
// R01: sixteen entries each keep speed, acceleration, deceleration and torque limit.
// R02: source select 0 makes every field of every entry digital.
// R03: source select 1 takes only entry zero speed from the analog input.
// R04: source select 2 takes torque limit from analog, everything else digital.
// R05: other source select values and out of range settings are rejected.
// R06: host writes 0 before relying on digital values; select resets to 1.
// R07: analog speed limited 100 to 4000, digital 80 to 4000, stored speed starts 0.
// R08: ramp times accept 0.2 to 15 s, start at 0.5 s.
// R09: torque limit 0 to 200 percent of rated, starts at 200.
// R10: speed gain 0 to 4000 r/min per volt, starts at 800.
// R11: signed speed offset -2000 to 2000 r/min, starts at 0, shifts analog speed.
// R12: maximum speed setting, starting 4000, caps analog speed.
// R13: higher analog input never gives lower commanded speed.
// R14: torque gain 0 to 200 percent per volt, starts at 40.
// R15: torque offset -50 to 50 percent, torque maximum starts at 200.
// R16: analog speed ramps refer to rated 3000 r/min, not target speed.
// R17: analog speed is gain times volts plus offset, clamped 0 to maximum.
`ifndef MCSS_CONSTS_SVH
`define MCSS_CONSTS_SVH

`define MCSS_ENTRIES       16
// speeds in r/min
`define MCSS_SPD_INIT      16'sh0000
`define MCSS_SPD_DIG_MIN   16'sh0050
`define MCSS_SPD_ANA_MIN   16'sh0064
`define MCSS_SPD_LIMIT     16'sh0fa0
`define MCSS_RATED_SPEED   16'sh0bb8
// ramp times in 0.1 s units
`define MCSS_RAMP_MIN      16'sh0002
`define MCSS_RAMP_MAX      16'sh0096
`define MCSS_RAMP_INIT     16'sh0005
// torque in percent of rated
`define MCSS_TRQ_LIMIT     16'sh00c8
`define MCSS_TRQ_INIT      16'sh00c8
// analog adjust settings
`define MCSS_SPD_GAIN_INIT 16'sh0320
`define MCSS_SPD_GAIN_MAX  16'sh0fa0
`define MCSS_SPD_OFS_LIM   16'sh07d0
`define MCSS_SPD_MAX_INIT  16'sh0fa0
`define MCSS_TRQ_GAIN_INIT 16'sh0028
`define MCSS_TRQ_GAIN_MAX  16'sh00c8
`define MCSS_TRQ_OFS_LIM   16'sh0032
`define MCSS_TRQ_MAX_INIT  16'sh00c8
// analog input in millivolts
`define MCSS_MV_PER_V      32'h000003e8
`define MCSS_ADC_FULL_MV   16'h2710
`define MCSS_DIV_STEPS     6'h20

`endif

/* rtl/mcss_pkg.sv */
package mcss_pkg;

   typedef enum logic [1:0] {
      MCSS_SRC_DIGITAL,
      MCSS_SRC_ANA_SPEED,
      MCSS_SRC_ANA_TORQUE
   } mcss_src_t;

   typedef enum logic [3:0] {
      MCSS_P_SPEED,
      MCSS_P_ACCEL,
      MCSS_P_DECEL,
      MCSS_P_TORQUE,
      MCSS_P_SRC_SEL,
      MCSS_P_SPD_GAIN,
      MCSS_P_SPD_OFS,
      MCSS_P_SPD_MAX,
      MCSS_P_TRQ_GAIN,
      MCSS_P_TRQ_OFS,
      MCSS_P_TRQ_MAX
   } mcss_param_t;

   typedef enum logic [1:0] {
      MCSS_SCL_IDLE,
      MCSS_SCL_DIV,
      MCSS_SCL_ADD,
      MCSS_SCL_DONE
   } mcss_scl_state_t;

endpackage

/* rtl/mcss_scale_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface mcss_scale_if;
   logic               start;
   logic        [15:0] gain;
   logic        [15:0] code;
   logic signed [15:0] offset;
   logic        [15:0] maxv;
   logic               done;
   logic        [15:0] result;

   modport client (output start, gain, code, offset, maxv, input done, result);
   modport scaler (input start, gain, code, offset, maxv, output done, result);
endinterface

`default_nettype wire

/* rtl/mcss_scaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcss_consts.svh"

module mcss_scaler (
   input  wire logic     clk,
   input  wire logic     reset,
   mcss_scale_if.scaler  sif
);

   mcss_pkg::mcss_scl_state_t state_reg;
   logic        [31:0] dvd_reg;
   logic        [31:0] rem_reg;
   logic        [31:0] quot_reg;
   logic         [5:0] cnt_reg;
   logic signed [15:0] ofs_reg;
   logic        [15:0] max_reg;
   logic        [15:0] result_reg;
   logic               done_reg;
   logic        [31:0] rem_next;
   logic signed [33:0] sum_next;

   assign sif.done   = done_reg;
   assign sif.result = result_reg;

   // ***********************************************
   // gain times millivolts, divided per volt
   // ***********************************************
   always_comb begin
      rem_next = {rem_reg[30:0], dvd_reg[31]};
      sum_next = $signed({2'b00, quot_reg}) + 34'(ofs_reg);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg  <= mcss_pkg::MCSS_SCL_IDLE;
         dvd_reg    <= 32'h0;
         rem_reg    <= 32'h0;
         quot_reg   <= 32'h0;
         cnt_reg    <= 6'h0;
         ofs_reg    <= 16'sh0;
         max_reg    <= 16'h0;
         result_reg <= 16'h0;
         done_reg   <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            mcss_pkg::MCSS_SCL_IDLE: begin
               if (sif.start) begin
                  // R17 gain times millivolts
                  dvd_reg   <= sif.gain * sif.code;
                  rem_reg   <= 32'h0;
                  quot_reg  <= 32'h0;
                  cnt_reg   <= `MCSS_DIV_STEPS;
                  ofs_reg   <= sif.offset;
                  max_reg   <= sif.maxv;
                  state_reg <= mcss_pkg::MCSS_SCL_DIV;
               end
            end
            mcss_pkg::MCSS_SCL_DIV: begin
               dvd_reg <= {dvd_reg[30:0], 1'b0};
               cnt_reg <= cnt_reg - 6'h1;
               if (rem_next >= `MCSS_MV_PER_V) begin
                  rem_reg  <= rem_next - `MCSS_MV_PER_V;
                  quot_reg <= {quot_reg[30:0], 1'b1};
               end else begin
                  rem_reg  <= rem_next;
                  quot_reg <= {quot_reg[30:0], 1'b0};
               end
               if (cnt_reg == 6'h1) begin
                  state_reg <= mcss_pkg::MCSS_SCL_ADD;
               end
            end
            mcss_pkg::MCSS_SCL_ADD: begin
               // R17 offset then clamp
               if (sum_next < 34'sh0) begin
                  result_reg <= 16'h0;
               end else if (sum_next > $signed({18'h0, max_reg})) begin
                  result_reg <= max_reg;
               end else begin
                  result_reg <= sum_next[15:0];
               end
               state_reg <= mcss_pkg::MCSS_SCL_DONE;
            end
            mcss_pkg::MCSS_SCL_DONE: begin
               done_reg  <= 1'b1;
               state_reg <= mcss_pkg::MCSS_SCL_IDLE;
            end
            default: begin
               state_reg <= mcss_pkg::MCSS_SCL_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* rtl/mcss_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcss_consts.svh"

module mcss_top #(
   parameter int ENTRIES = `MCSS_ENTRIES
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               wr_en,
   input  wire logic         [3:0] wr_param,
   input  wire logic         [3:0] wr_entry,
   input  wire logic signed [15:0] wr_data,
   input  wire logic        [15:0] analog_mv,
   input  wire logic         [3:0] entry_sel,
   output logic                    wr_ack,
   output logic                    wr_reject,
   output logic              [1:0] src_sel,
   output logic             [15:0] cmd_speed,
   output logic             [15:0] cmd_accel,
   output logic             [15:0] cmd_decel,
   output logic             [15:0] cmd_torque,
   output logic                    ramp_to_rated,
   output logic             [15:0] analog_speed,
   output logic             [15:0] analog_torque
);

   // ***********************************************
   // storage
   // ***********************************************
   logic signed [15:0] spd_mem   [ENTRIES];
   logic signed [15:0] acc_mem   [ENTRIES];
   logic signed [15:0] dec_mem   [ENTRIES];
   logic signed [15:0] trq_mem   [ENTRIES];
   logic         [1:0] src_reg;
   logic signed [15:0] spd_gain_reg;
   logic signed [15:0] spd_ofs_reg;
   logic signed [15:0] spd_max_reg;
   logic signed [15:0] trq_gain_reg;
   logic signed [15:0] trq_ofs_reg;
   logic signed [15:0] trq_max_reg;
   logic               wr_ack_reg;
   logic               wr_reject_reg;
   logic               wr_ok_next;
   logic        [15:0] adc_s1_reg;
   logic        [15:0] adc_s2_reg;
   logic        [15:0] adc_s3_reg;
   logic        [15:0] adc_reg;
   logic               kick_reg;
   logic               spd_start_reg;
   logic               trq_start_reg;
   logic        [15:0] ana_spd_reg;
   logic        [15:0] ana_trq_reg;
   logic        [15:0] cmd_speed_reg;
   logic        [15:0] cmd_accel_reg;
   logic        [15:0] cmd_decel_reg;
   logic        [15:0] cmd_torque_reg;
   logic               ramp_rated_reg;

   mcss_scale_if spd_if ();
   mcss_scale_if trq_if ();

   function automatic logic mcss_in_range(input logic signed [15:0] v,
                                          input logic signed [15:0] lo,
                                          input logic signed [15:0] hi);
      mcss_in_range = (v >= lo) && (v <= hi);
   endfunction

   // ***********************************************
   // write checking
   // ***********************************************
   always_comb begin
      // R05 range and combination checks
      case (mcss_pkg::mcss_param_t'(wr_param))
         mcss_pkg::MCSS_P_SPEED: begin
            // R07 digital speed range
            wr_ok_next = mcss_in_range(wr_data, `MCSS_SPD_DIG_MIN, `MCSS_SPD_LIMIT);
         end
         mcss_pkg::MCSS_P_ACCEL, mcss_pkg::MCSS_P_DECEL: begin
            // R08 ramp range
            wr_ok_next = mcss_in_range(wr_data, `MCSS_RAMP_MIN, `MCSS_RAMP_MAX);
         end
         mcss_pkg::MCSS_P_TORQUE: begin
            // R09 torque range
            wr_ok_next = mcss_in_range(wr_data, 16'sh0, `MCSS_TRQ_LIMIT);
         end
         mcss_pkg::MCSS_P_SRC_SEL: begin
            // R05 three combinations only
            wr_ok_next = mcss_in_range(wr_data, 16'sh0, 16'sh2);
         end
         mcss_pkg::MCSS_P_SPD_GAIN: begin
            // R10 gain range
            wr_ok_next = mcss_in_range(wr_data, 16'sh0, `MCSS_SPD_GAIN_MAX);
         end
         mcss_pkg::MCSS_P_SPD_OFS: begin
            // R11 offset range
            wr_ok_next = mcss_in_range(wr_data, -`MCSS_SPD_OFS_LIM, `MCSS_SPD_OFS_LIM);
         end
         mcss_pkg::MCSS_P_SPD_MAX: begin
            wr_ok_next = mcss_in_range(wr_data, 16'sh0, `MCSS_SPD_LIMIT);
         end
         mcss_pkg::MCSS_P_TRQ_GAIN: begin
            // R14 gain range
            wr_ok_next = mcss_in_range(wr_data, 16'sh0, `MCSS_TRQ_GAIN_MAX);
         end
         mcss_pkg::MCSS_P_TRQ_OFS: begin
            // R15 offset range
            wr_ok_next = mcss_in_range(wr_data, -`MCSS_TRQ_OFS_LIM, `MCSS_TRQ_OFS_LIM);
         end
         mcss_pkg::MCSS_P_TRQ_MAX: begin
            wr_ok_next = mcss_in_range(wr_data, 16'sh0, `MCSS_TRQ_LIMIT);
         end
         default: begin
            wr_ok_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ack_reg    <= 1'b0;
         wr_reject_reg <= 1'b0;
      end else begin
         wr_ack_reg    <= wr_en && wr_ok_next;
         wr_reject_reg <= wr_en && !wr_ok_next;
      end
   end

   // ***********************************************
   // operation data entries
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         // R01 sixteen entries with initial values
         for (int i = 0; i < ENTRIES; i++) begin
            spd_mem[i] <= `MCSS_SPD_INIT;
            acc_mem[i] <= `MCSS_RAMP_INIT;
            dec_mem[i] <= `MCSS_RAMP_INIT;
            trq_mem[i] <= `MCSS_TRQ_INIT;
         end
      end else if (wr_en && wr_ok_next) begin
         case (mcss_pkg::mcss_param_t'(wr_param))
            mcss_pkg::MCSS_P_SPEED:  spd_mem[wr_entry] <= wr_data;
            mcss_pkg::MCSS_P_ACCEL:  acc_mem[wr_entry] <= wr_data;
            mcss_pkg::MCSS_P_DECEL:  dec_mem[wr_entry] <= wr_data;
            mcss_pkg::MCSS_P_TORQUE: trq_mem[wr_entry] <= wr_data;
            default: begin
            end
         endcase
      end
   end

   // ***********************************************
   // source select and analog adjust settings
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         // R06 analog speed after reset
         src_reg      <= 2'(mcss_pkg::MCSS_SRC_ANA_SPEED);
         spd_gain_reg <= `MCSS_SPD_GAIN_INIT;
         spd_ofs_reg  <= 16'sh0;
         spd_max_reg  <= `MCSS_SPD_MAX_INIT;
         trq_gain_reg <= `MCSS_TRQ_GAIN_INIT;
         trq_ofs_reg  <= 16'sh0;
         trq_max_reg  <= `MCSS_TRQ_MAX_INIT;
      end else if (wr_en && wr_ok_next) begin
         case (mcss_pkg::mcss_param_t'(wr_param))
            mcss_pkg::MCSS_P_SRC_SEL:  src_reg      <= wr_data[1:0];
            mcss_pkg::MCSS_P_SPD_GAIN: spd_gain_reg <= wr_data;
            mcss_pkg::MCSS_P_SPD_OFS:  spd_ofs_reg  <= wr_data;
            mcss_pkg::MCSS_P_SPD_MAX:  spd_max_reg  <= wr_data;
            mcss_pkg::MCSS_P_TRQ_GAIN: trq_gain_reg <= wr_data;
            mcss_pkg::MCSS_P_TRQ_OFS:  trq_ofs_reg  <= wr_data;
            mcss_pkg::MCSS_P_TRQ_MAX:  trq_max_reg  <= wr_data;
            default: begin
            end
         endcase
      end
   end

   // ***********************************************
   // analog input synchroniser
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         adc_s1_reg <= 16'h0;
         adc_s2_reg <= 16'h0;
         adc_s3_reg <= 16'h0;
         adc_reg    <= 16'h0;
      end else begin
         adc_s1_reg <= analog_mv;
         adc_s2_reg <= adc_s1_reg;
         adc_s3_reg <= adc_s2_reg;
         if (adc_s2_reg == adc_s3_reg) begin
            adc_reg <= (adc_s3_reg > `MCSS_ADC_FULL_MV) ? `MCSS_ADC_FULL_MV : adc_s3_reg;
         end
      end
   end

   // ***********************************************
   // analog scaling
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         kick_reg      <= 1'b1;
         spd_start_reg <= 1'b0;
         trq_start_reg <= 1'b0;
      end else begin
         kick_reg      <= 1'b0;
         spd_start_reg <= kick_reg || spd_if.done;
         trq_start_reg <= kick_reg || trq_if.done;
      end
   end

   // R10 speed gain per volt
   assign spd_if.start  = spd_start_reg;
   assign spd_if.gain   = spd_gain_reg;
   assign spd_if.code   = adc_reg;
   // R11 speed offset
   assign spd_if.offset = spd_ofs_reg;
   // R12 maximum caps analog speed
   assign spd_if.maxv   = spd_max_reg;

   // R14 torque gain per volt
   assign trq_if.start  = trq_start_reg;
   assign trq_if.gain   = trq_gain_reg;
   assign trq_if.code   = adc_reg;
   // R15 torque offset and maximum
   assign trq_if.offset = trq_ofs_reg;
   assign trq_if.maxv   = trq_max_reg;

   mcss_scaler u_spd_scaler (
      .clk   (clk),
      .reset (reset),
      .sif   (spd_if.scaler)
   );

   mcss_scaler u_trq_scaler (
      .clk   (clk),
      .reset (reset),
      .sif   (trq_if.scaler)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         ana_spd_reg <= 16'h0;
         ana_trq_reg <= 16'h0;
      end else begin
         // R07 R13 below minimum stops, never reverses order
         if (spd_if.done) begin
            ana_spd_reg <= ($signed(spd_if.result) < `MCSS_SPD_ANA_MIN) ? 16'h0 : spd_if.result;
         end
         if (trq_if.done) begin
            ana_trq_reg <= trq_if.result;
         end
      end
   end

   // ***********************************************
   // command selection
   // ***********************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_speed_reg  <= 16'h0;
         cmd_accel_reg  <= 16'h0;
         cmd_decel_reg  <= 16'h0;
         cmd_torque_reg <= 16'h0;
         ramp_rated_reg <= 1'b0;
      end else begin
         cmd_accel_reg <= acc_mem[entry_sel];
         cmd_decel_reg <= dec_mem[entry_sel];
         // R03 only entry zero speed is analog
         if (src_reg == 2'(mcss_pkg::MCSS_SRC_ANA_SPEED) && entry_sel == 4'h0) begin
            cmd_speed_reg  <= ana_spd_reg;
            // R16 ramps refer to rated speed
            ramp_rated_reg <= 1'b1;
         end else begin
            // R02 digital speed
            cmd_speed_reg  <= spd_mem[entry_sel];
            ramp_rated_reg <= 1'b0;
         end
         // R04 analog torque limit
         if (src_reg == 2'(mcss_pkg::MCSS_SRC_ANA_TORQUE)) begin
            cmd_torque_reg <= ana_trq_reg;
         end else begin
            // R09 digital torque cap
            cmd_torque_reg <= trq_mem[entry_sel];
         end
      end
   end

   assign wr_ack        = wr_ack_reg;
   assign wr_reject     = wr_reject_reg;
   assign src_sel       = src_reg;
   assign cmd_speed     = cmd_speed_reg;
   assign cmd_accel     = cmd_accel_reg;
   assign cmd_decel     = cmd_decel_reg;
   assign cmd_torque    = cmd_torque_reg;
   assign ramp_to_rated = ramp_rated_reg;
   assign analog_speed  = ana_spd_reg;
   assign analog_torque = ana_trq_reg;

endmodule

`default_nettype wire

/* verif/mcss_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module mcss_top_checker #(
   parameter int ENTRIES = 16
) (
   input wire logic               clk,
   input wire logic               reset,
   input wire logic               wr_en,
   input wire logic         [3:0] wr_param,
   input wire logic         [3:0] wr_entry,
   input wire logic signed [15:0] wr_data,
   input wire logic        [15:0] analog_mv,
   input wire logic         [3:0] entry_sel,
   input wire logic               wr_ack,
   input wire logic               wr_reject,
   input wire logic         [1:0] src_sel,
   input wire logic        [15:0] cmd_speed,
   input wire logic        [15:0] cmd_accel,
   input wire logic        [15:0] cmd_decel,
   input wire logic        [15:0] cmd_torque,
   input wire logic               ramp_to_rated,
   input wire logic        [15:0] analog_speed,
   input wire logic        [15:0] analog_torque
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_write_answer: assert property (wr_en |=> (wr_ack != wr_reject))
      else $error("write not answered by exactly one of ack and reject");
   a_idle_silent: assert property (!wr_en |=> (!wr_ack && !wr_reject))
      else $error("answer without a write");
   a_bad_src_refused: assert property (
      wr_en && wr_param == 4'h4 && (wr_data < 0 || wr_data > 2) |=> wr_reject)
      else $error("illegal source select not refused");
   a_src_legal: assert property (src_sel <= 2'h2)
      else $error("source select outside defined values");
   a_ana_speed_range: assert property (
      analog_speed == 16'h0000 || (analog_speed >= 16'h0064 && analog_speed <= 16'h0fa0))
      else $error("analog speed outside allowed range");
   a_ana_torque_cap: assert property (analog_torque <= 16'h00c8)
      else $error("analog torque above cap");
   a_ramp_bounds: assert property (!$past(reset) |->
      cmd_accel inside {[16'h0002:16'h0096]} && cmd_decel inside {[16'h0002:16'h0096]})
      else $error("ramp time outside allowed range");
   a_cmd_caps: assert property (cmd_torque <= 16'h00c8 && cmd_speed <= 16'h0fa0)
      else $error("command above cap");
   a_rated_ramp: assert property (!$past(reset) |->
      ramp_to_rated == ($past(src_sel) == 2'h1 && $past(entry_sel) == 4'h0))
      else $error("ramp reference flag does not follow analog speed selection");
   a_speed_source: assert property (
      !$past(reset) && $past(src_sel) == 2'h1 && $past(entry_sel) == 4'h0
      |-> cmd_speed == $past(analog_speed))
      else $error("entry zero speed not taken from analog input");
   a_torque_source: assert property (
      !$past(reset) && $past(src_sel) == 2'h2 |-> cmd_torque == $past(analog_torque))
      else $error("torque limit not taken from analog input");
endmodule

bind mcss_top mcss_top_checker #(.ENTRIES(ENTRIES)) i_mcss_top_checker (.*);

`default_nettype wire

/* verif/mcss_ana_src.sv */
`timescale 1ns/1ps
`default_nettype none

module mcss_ana_src (
   input  wire logic        clk,
   input  wire logic [15:0] target_mv,
   output var  logic [15:0] analog_mv
);
   // knob turned at most 250 mV per clock
   initial analog_mv = 16'h0000;
   always @(posedge clk) begin
      if (target_mv > analog_mv + 16'h00fa)
         analog_mv <= analog_mv + 16'h00fa;
      else if (analog_mv > target_mv + 16'h00fa)
         analog_mv <= analog_mv - 16'h00fa;
      else
         analog_mv <= target_mv;
   end
endmodule

`default_nettype wire

/* verif/mcss_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g); end end

module mcss_top_tb;
   logic               clk, reset, wr_en, wr_ack, wr_reject, ramp_to_rated;
   logic         [3:0] wr_param, wr_entry, entry_sel;
   logic signed [15:0] wr_data;
   logic        [15:0] target_mv, analog_mv, cmd_speed, cmd_accel, cmd_decel, cmd_torque;
   logic        [15:0] analog_speed, analog_torque;
   logic         [1:0] src_sel;
   int                 n_mismatch, tests_run, seed, prev;
   int                 spd[16], acc[16], dec[16], trq[16];
   int                 src, sg, so, sm, tgn, tof, tmx, mv;
   int                 bp[17] = '{0, 0, 0, 1, 2, 3, 4, 4, 5, 6, 6, 7, 8, 9, 9, 10, 11};
   int                 bd[17] = '{79, 4001, 0, 1, 151, 201, 3, -1, 4001, 2001, -2001, 4001,
                                  201, 51, -51, 201, 0};

   mcss_top #(.ENTRIES(16)) i_mcss_top (.*);
   mcss_ana_src i_mcss_ana_src (.clk(clk), .target_mv(target_mv), .analog_mv(analog_mv));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic int ana_spd();
      int m, v;
      m = mv > 10000 ? 10000 : mv;
      v = sg * m / 1000 + so;
      v = v > sm ? sm : (v < 0 ? 0 : v);
      return v < 100 ? 0 : v;
   endfunction

   function automatic int ana_trq();
      int m, v;
      m = mv > 10000 ? 10000 : mv;
      v = tgn * m / 1000 + tof;
      return v > tmx ? tmx : (v < 0 ? 0 : v);
   endfunction

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr(int p, int e, int d, bit ok);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_param <= p[3:0];
      wr_entry <= e[3:0];
      wr_data <= d[15:0];
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
      `CHK("wr_ack", 1'(ok), wr_ack)
      `CHK("wr_reject", 1'(!ok), wr_reject)
      if (ok) begin
         case (p)
            0: spd[e] = d;
            1: acc[e] = d;
            2: dec[e] = d;
            3: trq[e] = d;
            4: src = d;
            5: sg = d;
            6: so = d;
            7: sm = d;
            8: tgn = d;
            9: tof = d;
            default: tmx = d;
         endcase
      end
   endtask

   task automatic chk_entry(int e);
      int es, et;
      @(posedge clk);
      entry_sel <= e[3:0];
      repeat (3) @(posedge clk);
      #1;
      es = (src == 1 && e == 0) ? ana_spd() : spd[e];
      et = src == 2 ? ana_trq() : trq[e];
      `CHK("cmd_speed", 16'(es), cmd_speed)
      `CHK("cmd_accel", 16'(acc[e]), cmd_accel)
      `CHK("cmd_decel", 16'(dec[e]), cmd_decel)
      `CHK("cmd_torque", 16'(et), cmd_torque)
      `CHK("ramp_to_rated", 1'(src == 1 && e == 0), ramp_to_rated)
      `CHK("src_sel", 2'(src), src_sel)
   endtask

   task automatic settle(int v);
      int k;
      @(posedge clk);
      target_mv <= 16'(v);
      mv = v;
      k = 0;
      #1;
      while (k < 400 && !(analog_speed === 16'(ana_spd()) && analog_torque === 16'(ana_trq())))
      begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 400) begin
         n_mismatch++;
         report_and_stop();
      end
      repeat (80) @(posedge clk);
      #1;
      `CHK("analog_speed", 16'(ana_spd()), analog_speed)
      `CHK("analog_torque", 16'(ana_trq()), analog_torque)
   endtask

   initial begin
      reset = 1'b1;
      wr_en = 1'b0;
      wr_param = 4'h0;
      wr_entry = 4'h0;
      wr_data = 16'sh0000;
      entry_sel = 4'h0;
      target_mv = 16'h0000;
      seed = 32'ha090;
      src = 1;
      sg = 800;
      so = 0;
      sm = 4000;
      tgn = 40;
      tof = 0;
      tmx = 200;
      mv = 0;
      for (int e = 0; e < 16; e++) begin
         spd[e] = 0;
         acc[e] = 5;
         dec[e] = 5;
         trq[e] = 200;
      end
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("src_sel", 2'h1, src_sel)
      for (int e = 0; e < 16; e++)
         chk_entry(e);
      settle(0);
      $display("test reset values done");
      for (int i = 0; i < 17; i++)
         wr(bp[i], 0, bd[i], 1'b0);
      chk_entry(0);
      $display("test refusals done");
      // digital values only after select 0
      wr(4, 0, 0, 1'b1);
      for (int e = 0; e < 16; e++) begin
         wr(0, e, 80 + $unsigned($random(seed)) % 3921, 1'b1);
         wr(1, e, 2 + $unsigned($random(seed)) % 149, 1'b1);
         wr(2, e, 2 + $unsigned($random(seed)) % 149, 1'b1);
         wr(3, e, $unsigned($random(seed)) % 201, 1'b1);
      end
      wr(0, 15, 80, 1'b1);
      wr(0, 14, 4000, 1'b1);
      wr(1, 15, 2, 1'b1);
      wr(2, 15, 150, 1'b1);
      wr(3, 15, 0, 1'b1);
      for (int e = 0; e < 16; e++)
         chk_entry(e);
      $display("test digital source done");
      wr(4, 0, 1, 1'b1);
      prev = 0;
      for (int v = 0; v <= 11250; v += 1250) begin
         settle(v);
         `CHK("speed_rising", 1'b1, 1'(analog_speed >= 16'(prev)))
         prev = analog_speed;
      end
      chk_entry(0);
      chk_entry(1);
      wr(5, 0, 400, 1'b1);
      wr(6, 0, -300, 1'b1);
      wr(7, 0, 2000, 1'b1);
      settle(6000);
      settle(500);
      settle(1000);
      settle($unsigned($random(seed)) % 10001);
      chk_entry(0);
      $display("test analog speed done");
      wr(4, 0, 2, 1'b1);
      wr(8, 0, 20, 1'b1);
      wr(9, 0, -10, 1'b1);
      wr(10, 0, 150, 1'b1);
      settle(9000);
      chk_entry(3);
      settle(200);
      chk_entry(5);
      settle($unsigned($random(seed)) % 10001);
      chk_entry(0);
      $display("test analog torque done");
      report_and_stop();
   end
endmodule

`default_nettype wire
